// ---- src/pcx_crossbar.sv ----
// Crossbar and port pin configuration for an eight-pin port.
// Assumes a single-cycle register port and open-drain capable pads.
`timescale 1ns/1ps
// Contract
// - Each pin is GPIO, analog input or one peripheral pin.
// - Port latch read returns actual pin level always.
// - Enabled functions placed in fixed priority on lowest free pin.
// - An assigned pin is passed over for later functions.
// - Skipped pins count as taken.
// - Skip bit n maps to pin n.
// - Serial transmit fixed at pin 4, receive at pin 5.
// - Transmit and receive enabled individually.
// - Two-wire bus data and clock assigned together; data is placed alone when only one pin is free.
// - Leftover pins stay GPIO.
// - Input mode 1 digital, 0 analog; resets digital.
// - Analog pin with crossbar enabled: pull-up, driver and receiver off.
// - Output mode bit picks open-drain or push-pull for every pin but the two-wire bus pins.
// - Two-wire bus pins always open-drain.
// - Pull-up disable 0 enables pull-ups on open-drain pins.
// - Open-drain pin driving low has pull-up off.
// - Crossbar disabled keeps all pins digital inputs, drivers off.
module pcx_crossbar #(
	parameter int PINS = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Peripheral outputs
	input wire logic uart_tx_i,
	input wire logic smb_sda_out_i,
	input wire logic smb_scl_out_i,
	input wire logic sysclk_out_i,
	input wire logic cmp_out_i,
	input wire logic cmp_async_out_i,
	input wire logic [2:0] pca_out_i,
	// Peripheral inputs
	output logic uart_rx_o,
	output logic smb_sda_in_o,
	output logic smb_scl_in_o,
	output logic [2:0] pca_in_o,
	output logic eci_in_o,
	output logic t0_in_o,
	output logic t1_in_o,
	// Port pins
	input wire logic [PINS-1:0] pad_in_i,
	output logic [PINS-1:0] pad_out_o,
	output logic [PINS-1:0] pad_oe_o,
	output logic [PINS-1:0] pad_pullup_o,
	output logic [PINS-1:0] pad_rx_en_o
);
	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] skip_reg, sel_a_reg, sel_b_reg, in_mode_reg, out_mode_reg, latch_reg;
	logic [PINS-1:0] pad_s1_reg, pad_s2_reg;
	logic [7:0] latch_next;
	wire wr_skip = sfr_wr_i && (sfr_addr_i == pcx_pkg::PIN_SKIP_ADDR);
	wire wr_sel_a = sfr_wr_i && (sfr_addr_i == pcx_pkg::RES_SEL_A_ADDR);
	wire wr_sel_b = sfr_wr_i && (sfr_addr_i == pcx_pkg::RES_SEL_B_ADDR);
	wire wr_in = sfr_wr_i && (sfr_addr_i == pcx_pkg::IN_MODE_ADDR);
	wire wr_out = sfr_wr_i && (sfr_addr_i == pcx_pkg::OUT_MODE_ADDR);
	wire wr_latch = sfr_wr_i && (sfr_addr_i == pcx_pkg::PORT_LATCH_ADDR);
	assign latch_next = wr_latch ? sfr_wdata_i : latch_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			skip_reg <= pcx_pkg::PIN_SKIP_RST;
			sel_a_reg <= pcx_pkg::RES_SEL_A_RST;
			sel_b_reg <= pcx_pkg::RES_SEL_B_RST;
			in_mode_reg <= pcx_pkg::IN_MODE_RST;
			out_mode_reg <= pcx_pkg::OUT_MODE_RST;
			latch_reg <= pcx_pkg::PORT_LATCH_RST;
			pad_s1_reg <= '0;
			pad_s2_reg <= '0;
		end else begin
			if (wr_skip) skip_reg <= sfr_wdata_i;
			if (wr_sel_a) sel_a_reg <= sfr_wdata_i;
			if (wr_sel_b) sel_b_reg <= sfr_wdata_i;
			if (wr_in) in_mode_reg <= sfr_wdata_i;
			if (wr_out) out_mode_reg <= sfr_wdata_i;
			latch_reg <= latch_next;
			pad_s1_reg <= pad_in_i;
			pad_s2_reg <= pad_s1_reg;
		end
	end

	// ************************************************************
	// Register read
	// ************************************************************
	always_comb begin
		unique case (sfr_addr_i)
			pcx_pkg::PIN_SKIP_ADDR: sfr_rdata_o = skip_reg;
			pcx_pkg::RES_SEL_A_ADDR: sfr_rdata_o = sel_a_reg;
			pcx_pkg::RES_SEL_B_ADDR: sfr_rdata_o = sel_b_reg;
			pcx_pkg::IN_MODE_ADDR: sfr_rdata_o = in_mode_reg;
			pcx_pkg::OUT_MODE_ADDR: sfr_rdata_o = out_mode_reg;
			pcx_pkg::PORT_LATCH_ADDR: sfr_rdata_o = pad_s2_reg;
			default: sfr_rdata_o = 8'h00;
		endcase
	end

	// ************************************************************
	// Function requests
	// ************************************************************
	localparam int NS = pcx_pkg::NUM_SLOTS;
	wire xbar_en = sel_b_reg[pcx_pkg::SEL_B_XBE];
	wire tx_en = sel_a_reg[pcx_pkg::SEL_A_TX];
	wire rx_en = sel_a_reg[pcx_pkg::SEL_A_RX];
	wire smb_en = sel_a_reg[pcx_pkg::SEL_A_SMB];
	wire [1:0] pca_sel = sel_a_reg[pcx_pkg::SEL_A_PCA_LO +: 2];
	logic [NS-1:0] slot_req, slot_ok;
	logic [NS*3-1:0] slot_pin;
	logic [PINS-1:0] fixed_taken, pin_used;
	assign slot_req = {sel_b_reg[pcx_pkg::SEL_B_T1],
		sel_b_reg[pcx_pkg::SEL_B_T0],
		sel_b_reg[pcx_pkg::SEL_B_ECI],
		pca_sel == 2'h3,
		pca_sel >= 2'h2,
		pca_sel != 2'h0,
		sel_a_reg[pcx_pkg::SEL_A_CMPA],
		sel_a_reg[pcx_pkg::SEL_A_CMP],
		sel_a_reg[pcx_pkg::SEL_A_SYSCK],
		smb_en, smb_en};

	// Serial pins bypass priority placement
	always_comb begin
		fixed_taken = skip_reg[PINS-1:0];
		if (tx_en) fixed_taken[pcx_pkg::TX_PIN] = 1'b1;
		if (rx_en) fixed_taken[pcx_pkg::RX_PIN] = 1'b1;
	end

	pcx_slot_decoder #(.PINS(PINS), .SLOTS(NS)) u_dec (
		.slot_req_i(slot_req),
		.taken_i(fixed_taken),
		.slot_ok_o(slot_ok),
		.slot_pin_o(slot_pin),
		.pin_used_o(pin_used)
	);

	// ************************************************************
	// Per-pin routing
	// ************************************************************
	logic [NS-1:0] slot_val;
	assign slot_val = {1'b1, 1'b1, 1'b1, pca_out_i[2], pca_out_i[1], pca_out_i[0],
		cmp_async_out_i, cmp_out_i, sysclk_out_i, smb_scl_out_i, smb_sda_out_i};
	// Input-only slots drive nothing
	localparam logic [NS-1:0] SLOT_DRIVES = 11'h0FF;

	logic [PINS-1:0] periph_pin, periph_drv, periph_val, smb_pin, placed_pin;
	always_comb begin
		periph_pin = '0;
		periph_drv = '0;
		periph_val = '0;
		smb_pin = '0;
		placed_pin = '0;
		for (int s = 0; s < NS; s++) begin
			if (slot_ok[s]) begin
				periph_pin[slot_pin[s*3 +: 3]] = 1'b1;
				placed_pin[slot_pin[s*3 +: 3]] = 1'b1;
				periph_drv[slot_pin[s*3 +: 3]] = SLOT_DRIVES[s];
				periph_val[slot_pin[s*3 +: 3]] = slot_val[s];
				if (s == pcx_pkg::SLOT_SDA || s == pcx_pkg::SLOT_SCL)
					smb_pin[slot_pin[s*3 +: 3]] = 1'b1;
			end
		end
		if (tx_en) begin
			periph_pin[pcx_pkg::TX_PIN] = 1'b1;
			periph_drv[pcx_pkg::TX_PIN] = 1'b1;
			periph_val[pcx_pkg::TX_PIN] = uart_tx_i;
		end
		if (rx_en) begin
			periph_pin[pcx_pkg::RX_PIN] = 1'b1;
			periph_val[pcx_pkg::RX_PIN] = 1'b1;
		end
	end

	// Input lookups for peripheral receivers
	function automatic logic pin_level(input logic ok, input logic [2:0] pin,
		input logic [PINS-1:0] lvl);
		pin_level = ok ? lvl[pin] : 1'b1;
	endfunction

	wire [PINS-1:0] digital = in_mode_reg[PINS-1:0];
	wire [PINS-1:0] rx_lvl = pad_s2_reg & digital;
	assign uart_rx_o = rx_en ? rx_lvl[pcx_pkg::RX_PIN] : 1'b1;
	assign smb_sda_in_o = pin_level(slot_ok[0], slot_pin[2:0], rx_lvl);
	assign smb_scl_in_o = pin_level(slot_ok[1], slot_pin[5:3], rx_lvl);
	assign pca_in_o[0] = pin_level(slot_ok[5], slot_pin[17:15], rx_lvl);
	assign pca_in_o[1] = pin_level(slot_ok[6], slot_pin[20:18], rx_lvl);
	assign pca_in_o[2] = pin_level(slot_ok[7], slot_pin[23:21], rx_lvl);
	assign eci_in_o = pin_level(slot_ok[8], slot_pin[26:24], rx_lvl);
	assign t0_in_o = pin_level(slot_ok[9], slot_pin[29:27], rx_lvl);
	assign t1_in_o = pin_level(slot_ok[10], slot_pin[32:30], rx_lvl);

	// ************************************************************
	// Pad control
	// ************************************************************
	wire pud = sel_b_reg[pcx_pkg::SEL_B_PUD];
	logic [PINS-1:0] drv_val, open_drain, gpio_pin;
	// Leftover pins fall back to the port latch
	assign gpio_pin = ~periph_pin;
	assign drv_val = (periph_pin & periph_val) | (gpio_pin & latch_reg[PINS-1:0]);
	assign open_drain = ~out_mode_reg[PINS-1:0] | smb_pin;

	always_comb begin
		for (int p = 0; p < PINS; p++) begin
			if (!xbar_en) begin
				pad_out_o[p] = 1'b0;
				pad_oe_o[p] = 1'b0;
				pad_pullup_o[p] = digital[p] && !pud;
				pad_rx_en_o[p] = 1'b1;
			end else if (!digital[p]) begin
				pad_out_o[p] = 1'b0;
				pad_oe_o[p] = 1'b0;
				pad_pullup_o[p] = 1'b0;
				pad_rx_en_o[p] = 1'b0;
			end else begin
				pad_out_o[p] = drv_val[p];
				pad_oe_o[p] = (gpio_pin[p] || periph_drv[p]) &&
					(!open_drain[p] || !drv_val[p]);
				pad_pullup_o[p] = open_drain[p] && !pud && drv_val[p];
				pad_rx_en_o[p] = 1'b1;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_disabled_no_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!xbar_en |-> pad_oe_o == '0) else $error("driver on while disabled");
	a_analog_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en |-> (pad_pullup_o & ~digital) == '0 && (pad_rx_en_o & ~digital) == '0)
		else $error("analog pin not isolated");
	a_tx_fixed_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en && tx_en && digital[pcx_pkg::TX_PIN] && !open_drain[pcx_pkg::TX_PIN]
		|-> pad_oe_o[pcx_pkg::TX_PIN] && pad_out_o[pcx_pkg::TX_PIN] == uart_tx_i)
		else $error("transmit not on its pin");
	a_smb_open_drain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en |-> (smb_pin & pad_oe_o & pad_out_o) == '0)
		else $error("bus pin driven high");
	a_skip_no_slot: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(placed_pin & skip_reg[PINS-1:0]) == '0) else $error("peripheral on skipped pin");
	a_smb_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		slot_ok[1] |-> slot_ok[0]) else $error("bus lines not paired");
	a_pullup_low_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pad_pullup_o & pad_oe_o & ~pad_out_o) == '0)
		else $error("pull-up on while low");
	a_latch_reads_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sfr_addr_i == pcx_pkg::PORT_LATCH_ADDR |-> sfr_rdata_o == $past(pad_s1_reg))
		else $error("latch read not pin level");
	a_in_mode_reset: assert property (@(posedge ref_clk_i)
		$past(rst_i) |-> in_mode_reg == pcx_pkg::IN_MODE_RST) else $error("input mode reset");

	// ************************************************************
	// Placement and pad checks
	// ************************************************************
	function automatic logic [2:0] first_free(input logic [PINS-1:0] taken);
		first_free = 3'h0;
		for (int p = PINS - 1; p >= 0; p--) begin
			if (!taken[p]) first_free = 3'(p);
		end
	endfunction
	wire [PINS-1:0] slot0_mask = PINS'(1) << slot_pin[2:0];
	a_first_slot_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		slot_ok[0] |-> slot_pin[2:0] == first_free(fixed_taken))
		else $error("first function not on lowest free pin");
	a_next_slot_skips: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		slot_ok[1] |-> slot_pin[5:3] == first_free(fixed_taken | slot0_mask))
		else $error("assigned pin not passed over");
	a_unplaced_full: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(slot_req & ~slot_ok) != '0 |-> pin_used == '1)
		else $error("function dropped with a free pin");
	a_pud_no_pullup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en && pud |-> pad_pullup_o == '0) else $error("pull-up on while disabled");
	a_od_pullup_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en && !pud |-> (open_drain & digital & drv_val & ~pad_pullup_o) == '0)
		else $error("open-drain pin without pull-up");
	a_pushpull_no_pullup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en |-> (pad_pullup_o & ~open_drain) == '0) else $error("pull-up on push-pull pin");
	a_analog_no_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en |-> (pad_oe_o & ~digital) == '0) else $error("analog pin driven");
	a_digital_rx_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en |-> pad_rx_en_o == digital) else $error("receiver enable wrong");
	a_smb_pins_od: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(smb_pin & ~open_drain) == '0) else $error("bus pin not open-drain");
	a_rx_not_driven: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en && rx_en |-> !pad_oe_o[pcx_pkg::RX_PIN])
		else $error("receive pin driven");
	a_rx_fixed_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rx_en && digital[pcx_pkg::RX_PIN] |-> uart_rx_o == pad_s2_reg[pcx_pkg::RX_PIN])
		else $error("receive not from its pin");
	a_gpio_latch_out: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		xbar_en |-> ((pad_out_o ^ latch_reg[PINS-1:0]) & gpio_pin & digital) == '0)
		else $error("free pin not following latch");
	a_disabled_rx_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!xbar_en |-> pad_rx_en_o == '1 && pad_out_o == '0) else $error("disabled pin not input");
	a_sel_reset: assert property (@(posedge ref_clk_i)
		$past(rst_i) |-> !xbar_en) else $error("crossbar on after reset");
endmodule

// ---- src/pcx_pkg.sv ----
// Constants for the priority crossbar port block.
// Assumes an eight-bit special function register port from the core.
package pcx_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] PIN_SKIP_ADDR = 8'hE1;
	localparam logic [7:0] RES_SEL_A_ADDR = 8'hE2;
	localparam logic [7:0] RES_SEL_B_ADDR = 8'hE3;
	localparam logic [7:0] IN_MODE_ADDR = 8'hF1;
	localparam logic [7:0] OUT_MODE_ADDR = 8'hA4;
	localparam logic [7:0] PORT_LATCH_ADDR = 8'h80;
	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] PIN_SKIP_RST = 8'h00;
	localparam logic [7:0] RES_SEL_A_RST = 8'h00;
	localparam logic [7:0] RES_SEL_B_RST = 8'h00;
	localparam logic [7:0] IN_MODE_RST = 8'hFF;
	localparam logic [7:0] OUT_MODE_RST = 8'h00;
	localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
	// ************************************************************
	// Field positions, select A
	// ************************************************************
	localparam int SEL_A_TX = 0;
	localparam int SEL_A_RX = 1;
	localparam int SEL_A_SMB = 2;
	localparam int SEL_A_SYSCK = 3;
	localparam int SEL_A_CMP = 4;
	localparam int SEL_A_CMPA = 5;
	localparam int SEL_A_PCA_LO = 6;
	// ************************************************************
	// Field positions, select B
	// ************************************************************
	localparam int SEL_B_ECI = 0;
	localparam int SEL_B_T0 = 1;
	localparam int SEL_B_T1 = 2;
	localparam int SEL_B_PUD = 6;
	localparam int SEL_B_XBE = 7;
	// ************************************************************
	// Fixed serial pins and slot list
	// ************************************************************
	localparam int TX_PIN = 4;
	localparam int RX_PIN = 5;
	localparam int NUM_SLOTS = 11;
	localparam int SLOT_SDA = 0;
	localparam int SLOT_SCL = 1;
endpackage

// ---- src/pcx_slot_decoder.sv ----
// Priority placement of prioritised functions onto pins.
// Assumes combinational use inside the crossbar top.
`timescale 1ns/1ps
module pcx_slot_decoder #(
	parameter int PINS = 8,
	parameter int SLOTS = 11
) (
	// Requests and claimed pins
	input wire logic [SLOTS-1:0] slot_req_i,
	input wire logic [PINS-1:0] taken_i,
	// Placement
	output logic [SLOTS-1:0] slot_ok_o,
	output logic [SLOTS*3-1:0] slot_pin_o,
	output logic [PINS-1:0] pin_used_o
);
	// ************************************************************
	// Sequential lowest free pin search
	// ************************************************************
	always_comb begin
		logic [PINS-1:0] used;
		logic found;
		found = 1'b0;
		used = taken_i;
		slot_ok_o = '0;
		slot_pin_o = '0;
		for (int s = 0; s < SLOTS; s++) begin
			found = 1'b0;
			if (slot_req_i[s]) begin
				for (int p = 0; p < PINS; p++) begin
					if (!found && !used[p]) begin
						found = 1'b1;
						used[p] = 1'b1;
						slot_ok_o[s] = 1'b1;
						slot_pin_o[s*3 +: 3] = 3'(p);
					end
				end
			end
		end
		// Unplaced slots stay unconnected
		pin_used_o = used;
	end
endmodule

// ---- verification/pcx_crossbar_bench.sv ----
// Self-checking bench for the crossbar through its register port.
// Assumes the pin model drives the pad inputs.
`timescale 1ns/1ps
module pcx_crossbar_bench;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [8:0] pdrv = 9'h007;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] rdata;
	logic [7:0] p_out;
	logic [7:0] p_oe;
	logic [7:0] p_pu;
	logic [7:0] p_rx;
	logic [7:0] p_in;
	logic rx;
	logic sda_in;
	logic scl_in;
	logic eci_in;
	logic t0_in;
	logic t1_in;
	logic [2:0] pca_in;
	int fails = 0;
	int n_tests = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	pcx_crossbar i_pcx_crossbar (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .uart_tx_i(pdrv[0]),
		.smb_sda_out_i(pdrv[1]), .smb_scl_out_i(pdrv[2]), .sysclk_out_i(pdrv[3]),
		.cmp_out_i(pdrv[4]), .cmp_async_out_i(pdrv[5]), .pca_out_i(pdrv[8:6]),
		.uart_rx_o(rx), .smb_sda_in_o(sda_in), .smb_scl_in_o(scl_in), .pca_in_o(pca_in),
		.eci_in_o(eci_in), .t0_in_o(t0_in), .t1_in_o(t1_in), .pad_in_i(p_in), .pad_out_o(p_out),
		.pad_oe_o(p_oe),
		.pad_pullup_o(p_pu), .pad_rx_en_o(p_rx));
	pcx_pin_model i_pcx_pin_model (.ref_clk_i(ref_clk_i), .pad_out_i(p_out), .pad_oe_i(p_oe),
		.pad_pullup_i(p_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(p_in));
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge ref_clk_i);
		wr = 1'b0;
		@(negedge ref_clk_i);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		#1;
		chk(rdata, exp);
		@(negedge ref_clk_i);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ************************************************************
	// Watchdog
	// ************************************************************
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		fails++;
		finish_test();
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (20) @(negedge ref_clk_i);
		rst_i = 1'b0;
		@(negedge ref_clk_i);
		rd_reg(pcx_pkg::PIN_SKIP_ADDR, 8'h00);
		rd_reg(pcx_pkg::RES_SEL_A_ADDR, 8'h00);
		rd_reg(pcx_pkg::RES_SEL_B_ADDR, 8'h00);
		rd_reg(pcx_pkg::IN_MODE_ADDR, 8'hFF);
		rd_reg(pcx_pkg::OUT_MODE_ADDR, 8'h00);
		rd_reg(8'h55, 8'h00);
		chk(p_oe, 8'h00);
		chk(p_rx, 8'hFF);
		chk(p_pu, 8'hFF);
		// Configure in documented order, pin 2 analog, pin 6 conversion start
		wr_reg(pcx_pkg::IN_MODE_ADDR, 8'hFB);
		wr_reg(pcx_pkg::OUT_MODE_ADDR, 8'h98);
		wr_reg(pcx_pkg::PIN_SKIP_ADDR, 8'h44);
		wr_reg(pcx_pkg::RES_SEL_A_ADDR, 8'h3F);
		wr_reg(8'h55, 8'hAA);
		rd_reg(8'h55, 8'h00);
		rd_reg(pcx_pkg::PIN_SKIP_ADDR, 8'h44);
		pdrv = 9'h01C;
		ext_en = 8'h60;
		#1;
		chk(p_oe, 8'h00);
		@(negedge ref_clk_i);
		wr_reg(pcx_pkg::RES_SEL_B_ADDR, 8'h80);
		#1;
		chk(p_oe, 8'h99);
		chk(p_out & 8'h99, 8'h88);
		chk(p_pu, 8'h62);
		chk(p_rx, 8'hFB);
		repeat (3) @(negedge ref_clk_i);
		chk({7'h00, rx}, 8'h00);
		chk({6'h00, sda_in, scl_in}, 8'h01);
		addr = pcx_pkg::PORT_LATCH_ADDR;
		#1;
		chk(rdata & 8'hFB, 8'h8A);
		@(negedge ref_clk_i);
		pdrv = 9'h028;
		#1;
		chk(p_out & 8'h80, 8'h00);
		chk(p_oe & 8'h03, 8'h03);
		@(negedge ref_clk_i);
		wr_reg(pcx_pkg::PORT_LATCH_ADDR, 8'hBF);
		#1;
		chk(p_oe & 8'h40, 8'h40);
		chk(p_out & 8'h40, 8'h00);
		@(negedge ref_clk_i);
		wr_reg(pcx_pkg::RES_SEL_B_ADDR, 8'hC0);
		#1;
		chk(p_pu, 8'h00);
		@(negedge ref_clk_i);
		wr_reg(pcx_pkg::RES_SEL_A_ADDR, 8'h01);
		repeat (3) @(negedge ref_clk_i);
		chk({7'h00, rx}, 8'h01);
		chk(p_oe & 8'h10, 8'h10);
		// Input-only functions on pins 0, 1, 3; pins 1 and 3 pulled low outside
		ext_en = 8'h6A;
		wr_reg(pcx_pkg::RES_SEL_B_ADDR, 8'h87);
		repeat (3) @(negedge ref_clk_i);
		chk({3'h0, sda_in, scl_in, eci_in, t0_in, t1_in}, 8'h1C);
		chk({5'h00, pca_in}, 8'h07);
		finish_test();
	end
endmodule

// ---- verification/pcx_pin_model.sv ----
// External circuitry model on the eight port pins.
// Assumes pad controls from the crossbar and a bench-driven source.
`timescale 1ns/1ps
module pcx_pin_model (
	// Clock
	input wire logic ref_clk_i,
	// Pad controls
	input wire logic [7:0] pad_out_i,
	input wire logic [7:0] pad_oe_i,
	input wire logic [7:0] pad_pullup_i,
	// External source
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_val_i,
	// Pin levels
	output logic [7:0] pad_in_o
);
	// ************************************************************
	// Pin resolution
	// ************************************************************
	logic [7:0] float_reg = 8'h00;
	always_ff @(posedge ref_clk_i) begin
		float_reg <= ~pad_in_o;
	end
	// Undriven pin without pull-up flips each cycle
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe_i[i]) begin
				pad_in_o[i] = pad_out_i[i];
			end else if (ext_en_i[i]) begin
				pad_in_o[i] = ext_val_i[i];
			end else if (pad_pullup_i[i]) begin
				pad_in_o[i] = 1'b1;
			end else begin
				pad_in_o[i] = float_reg[i];
			end
		end
	end
endmodule
